// ### adr_clk_ctrl.v
/*
  adr_clk_ctrl.v: clocking control for the converter: sampling-edge
  selection, aperture delay codes with coarse ramping, and system
  reference capture on a deterministic clock edge.
  assumes a classic wishbone master on core_clk and a sysref input that
  is already synchronous to core_clk.
*/
// The Wishbone slave port and the address map were decided locally.
// Functional notes
// - dual-channel mode samples on rising edges only, single-channel on both.
// - sysref is captured on a fixed clock edge; the source meets setup/hold.
// - single-channel mode uses dual-edge sampling, doubling the sysref window.
// - the half-period invert control delays sampling by half a clock period.
// - coarse and fine delay codes each offer 256 settings of one step each.
// - invert, coarse and fine delays are independent and add together.
// - the aperture delay shifts every internal clock, sysref capture included.
// - delay changes are accepted live and may briefly disturb the link.
// - the ramp moves the active coarse code one step at a time to its target.
// - ramp speed is one step per 256 clocks slow, four per 256 clocks fast.
// - with ramp enabled every coarse write starts a new ramp to that value.
`timescale 1ns/1ns
`include "adr_clk_defs.vh"

module adr_clk_ctrl
#(
  parameter CODE_W = 8
)
(
  // clock and reset
  input  wire              core_clk,
  input  wire              resetn,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // system reference
  input  wire              sysrefIn,
  // analog clock path controls
  output reg               halfPeriodInvert_q,
  output reg  [CODE_W-1:0] coarseDelayCode_q,
  output reg  [CODE_W-1:0] fineDelayCode_q,
  output reg               dualEdgeSample_q,
  output reg               sysrefCapt_q
);

  // software state
  reg               rampEnableBit_q;
  reg               rampSpeedSelect_q;
  reg  [CODE_W-1:0] coarseTarget_q;
  reg               sysrefSeen_q;
  reg               sysrefPrev_q;
  wire              stepTick;
  wire              busReq;
  wire              wrCtrl;
  wire              wrCoarse;
  wire              wrFine;
  wire              wrSysref;
  wire              rampBusy;
  wire              sysrefRise;
  reg  [31:0]       rdData;

  assign busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrCtrl   = busReq & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == `ADR_OFS_CTRL);
  assign wrCoarse = busReq & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == `ADR_OFS_COARSE);
  assign wrFine   = busReq & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == `ADR_OFS_FINE);
  assign wrSysref = busReq & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == `ADR_OFS_SYSREF);
  assign rampBusy = (coarseTarget_q != coarseDelayCode_q);
  // sysref is sampled on the (possibly delayed) device clock edge
  assign sysrefRise = sysrefIn & ~sysrefPrev_q;

  adr_ramp_tick
  #(
    .PERIOD (`ADR_RAMP_PERIOD)
  )
  u_tick
  (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .fastRate   (rampSpeedSelect_q),
    .stepTick_q (stepTick)
  );

  // bus answer: single-cycle ack, unmapped reads return zero
  always @*
  begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      `ADR_OFS_CTRL:
      begin
        rdData[`ADR_CTRL_INV]    = halfPeriodInvert_q;
        rdData[`ADR_CTRL_RAMPEN] = rampEnableBit_q;
        rdData[`ADR_CTRL_RATE]   = rampSpeedSelect_q;
        rdData[`ADR_CTRL_SINGLE] = dualEdgeSample_q;
      end
      `ADR_OFS_COARSE:
        rdData[CODE_W-1:0] = coarseTarget_q;
      `ADR_OFS_FINE:
        rdData[CODE_W-1:0] = fineDelayCode_q;
      `ADR_OFS_STATUS:
      begin
        rdData[`ADR_STAT_BUSY] = rampBusy;
        rdData[`ADR_STAT_ACT_LSB +: CODE_W] = coarseDelayCode_q;
      end
      `ADR_OFS_SYSREF:
        rdData[0] = sysrefSeen_q;
      default:
        rdData = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h0000_0000;
    end
  end

  // control bits; changes are accepted at any time during operation
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      halfPeriodInvert_q <= 1'b0;
      rampEnableBit_q    <= 1'b0;
      rampSpeedSelect_q  <= 1'b0;
      dualEdgeSample_q   <= 1'b0;
      fineDelayCode_q    <= `ADR_RST_CODE;
    end
    else
    begin
      if (wrCtrl)
      begin
        halfPeriodInvert_q <= wb_dat_i[`ADR_CTRL_INV];
        rampEnableBit_q    <= wb_dat_i[`ADR_CTRL_RAMPEN];
        rampSpeedSelect_q  <= wb_dat_i[`ADR_CTRL_RATE];
        // single-channel mode: sample on both edges
        dualEdgeSample_q   <= wb_dat_i[`ADR_CTRL_SINGLE];
      end
      if (wrFine)
        fineDelayCode_q <= wb_dat_i[CODE_W-1:0];
    end
  end

  // coarse code: ramp one step per tick, or jump when ramping is off
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      coarseTarget_q    <= `ADR_RST_CODE;
      coarseDelayCode_q <= `ADR_RST_CODE;
    end
    else
    begin
      if (wrCoarse)
      begin
        coarseTarget_q <= wb_dat_i[CODE_W-1:0];
        if (!rampEnableBit_q)
          coarseDelayCode_q <= wb_dat_i[CODE_W-1:0];
      end
      else if (rampEnableBit_q && stepTick && rampBusy)
      begin
        // single steps limit glitches on the internal clocks
        if (coarseTarget_q > coarseDelayCode_q)
          coarseDelayCode_q <= coarseDelayCode_q + 1'b1;
        else
          coarseDelayCode_q <= coarseDelayCode_q - 1'b1;
      end
      else if (!rampEnableBit_q && rampBusy)
        coarseDelayCode_q <= coarseTarget_q;
    end
  end

  // sysref capture: one pulse per rising edge, pulse or periodic alike
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sysrefPrev_q <= 1'b0;
      sysrefCapt_q <= 1'b0;
      sysrefSeen_q <= 1'b0;
    end
    else
    begin
      sysrefPrev_q <= sysrefIn;
      sysrefCapt_q <= sysrefRise;
      // set wins over a software clear in the same cycle
      if (sysrefRise)
        sysrefSeen_q <= 1'b1;
      else if (wrSysref && wb_dat_i[0])
        sysrefSeen_q <= 1'b0;
    end
  end

endmodule // adr_clk_ctrl

// ### adr_clk_defs.vh
/*
  adr_clk_defs.vh: register offsets, field positions, reset values and
  timing counts for the aperture delay ramp and clocking control block.
  assumes inclusion by bare name from the design, checker and test files.
*/
`ifndef ADR_CLK_DEFS_VH
`define ADR_CLK_DEFS_VH

// register byte offsets on the wishbone bus
`define ADR_OFS_CTRL      8'h00
`define ADR_OFS_COARSE    8'h04
`define ADR_OFS_FINE      8'h08
`define ADR_OFS_STATUS    8'h0C
`define ADR_OFS_SYSREF    8'h10

// control register fields
`define ADR_CTRL_INV      0
`define ADR_CTRL_RAMPEN   1
`define ADR_CTRL_RATE     2
`define ADR_CTRL_SINGLE   3

// status register fields
`define ADR_STAT_BUSY     0
`define ADR_STAT_ACT_LSB  8

// reset values
`define ADR_RST_CTRL      4'h0
`define ADR_RST_CODE      8'h00

// ramp timing: ramp period in clocks, steps per ramp period
`define ADR_RAMP_PERIOD   256
`define ADR_STEPS_SLOW    1
`define ADR_STEPS_FAST    4

`endif

// ### adr_ramp_tick.v
/*
  adr_ramp_tick.v: divider that emits one-cycle step enables for the
  coarse delay ramp, spread evenly over each ramp period.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "adr_clk_defs.vh"

module adr_ramp_tick
#(
  parameter PERIOD = `ADR_RAMP_PERIOD
)
(
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // control
  input  wire        fastRate,
  // step enable
  output reg         stepTick_q
);

  localparam integer LAST_FAST = PERIOD / `ADR_STEPS_FAST - 1;
  localparam integer LAST_SLOW = PERIOD / `ADR_STEPS_SLOW - 1;

  reg  [7:0]  divCnt_q;
  wire [7:0]  divLast;

  // fast rate wraps every quarter period: four steps per period
  assign divLast = fastRate ? LAST_FAST[7:0] : LAST_SLOW[7:0];

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      divCnt_q   <= 8'h00;
      stepTick_q <= 1'b0;
    end
    else
    begin
      stepTick_q <= (divCnt_q >= divLast);
      if (divCnt_q >= divLast)
        divCnt_q <= 8'h00;
      else
        divCnt_q <= divCnt_q + 8'h01;
    end
  end

endmodule // adr_ramp_tick

// ### adr_sysref_src.sv
/* adr_sysref_src.sv: model of the external source of the system reference.
   assumes it shares core_clk with the block it feeds. */
`timescale 1ns/1ns
module adr_sysref_src
#(
  parameter PER = 40
)
(
  // clock
  input  wire  core_clk,
  // bench control
  input  wire  fire,
  input  wire  periodic,
  // reference out
  output logic sysrefOut
);
  int cnt = 0;
  initial sysrefOut = 1'b0;
  // moves just after a rising edge so setup and hold are met
  always @(posedge core_clk)
  begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    if (periodic)
      sysrefOut <= (cnt < PER / 2);
    else
      sysrefOut <= fire;
  end
endmodule // adr_sysref_src

// ### adr_clk_ctrl_assertions.sv
/* adr_clk_ctrl_assertions.sv: checks on bus, capture and delay outputs.
   assumes binding onto adr_clk_ctrl. */
`timescale 1ns/1ns
`include "adr_clk_defs.vh"
module adr_clk_ctrl_assertions
#(
  parameter CODE_W = 8
)
(
  input wire              core_clk,
  input wire              resetn,
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_we_i,
  input wire [7:0]        wb_adr_i,
  input wire [3:0]        wb_sel_i,
  input wire [31:0]       wb_dat_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  input wire              sysrefIn,
  input wire              halfPeriodInvert_q,
  input wire [CODE_W-1:0] coarseDelayCode_q,
  input wire [CODE_W-1:0] fineDelayCode_q,
  input wire              dualEdgeSample_q,
  input wire              sysrefCapt_q
);
  reg  rampOn_q;
  wire wr = wb_ack_o & wb_we_i & wb_sel_i[0];
  // ramp state is internal, so it is rebuilt from control writes
  always @(posedge core_clk)
    if (!resetn)
      rampOn_q <= 1'b0;
    else if (wr && wb_adr_i == `ADR_OFS_CTRL)
      rampOn_q <= wb_dat_i[1];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sRise;
    !sysrefIn ##1 sysrefIn;
  endsequence
  AST_ACK_ONE: assert property (sReq |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_CAPT_RISE: assert property (sRise |=> sysrefCapt_q)
    else $error("capture missed");
  AST_CAPT_CAUSE: assert property (sysrefCapt_q |->
    $past(sysrefIn) && !$past(sysrefIn, 2))
    else $error("stray capture");
  AST_CTRL_WR: assert property (wr && wb_adr_i == `ADR_OFS_CTRL |->
    halfPeriodInvert_q == wb_dat_i[0] && dualEdgeSample_q == wb_dat_i[3])
    else $error("mode not applied");
  AST_FINE_WR: assert property (wr && wb_adr_i == `ADR_OFS_FINE |->
    fineDelayCode_q == wb_dat_i[CODE_W-1:0])
    else $error("fine not applied");
  AST_DIRECT: assert property (wr && wb_adr_i == `ADR_OFS_COARSE &&
    !rampOn_q |-> coarseDelayCode_q == wb_dat_i[CODE_W-1:0])
    else $error("coarse not direct");
  AST_RAMP_STEP: assert property (rampOn_q && !wb_stb_i |=>
    coarseDelayCode_q - $past(coarseDelayCode_q) inside {0, 1, '1})
    else $error("ramp jumped");
endmodule // adr_clk_ctrl_assertions
bind adr_clk_ctrl adr_clk_ctrl_assertions #(.CODE_W(CODE_W)) u_chk (.*);

// ### adr_clk_ctrl_test.sv
/* adr_clk_ctrl_test.sv: register, ramp and capture tests.
   assumes the checker is bound by its own file. */
`timescale 1ns/1ns
`include "adr_clk_defs.vh"
module adr_clk_ctrl_test;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, per = 1'b0;
  logic [7:0]  adr = 8'h00, c, e;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, dato;
  logic [7:0]  offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
  logic [3:0]  modes[4] = '{4'h1, 4'h8, 4'h9, 4'h0};
  wire         ack, inv, dual, capt, sref;
  wire  [7:0]  coarse, fine;
  int          failCount = 0, cmpCount = 0, rises = 0, caps = 0, n;
  logic        sPrev = 1'b0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    rises += (sref & ~sPrev);
    caps += capt;
    sPrev <= sref;
  end
  adr_clk_ctrl u_adr_clk_ctrl (.core_clk(core_clk), .resetn(resetn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .sysrefIn(sref), .halfPeriodInvert_q(inv), .coarseDelayCode_q(coarse),
    .fineDelayCode_q(fine), .dualEdgeSample_q(dual), .sysrefCapt_q(capt));
  adr_sysref_src u_adr_sysref_src (.core_clk(core_clk), .fire(fire),
    .periodic(per), .sysrefOut(sref));
  task automatic endSim;
    $display("compares %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
    cmpCount++;
    if (s !== x)
    begin
      $display("mismatch %s expected %h seen %h", nm, x, s);
      failCount++;
    end
  endtask
  task automatic xfer(logic [7:0] a, logic [31:0] d, logic w);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge core_clk);
    if (n == 20)
      chk("ack", 1, 0);
    if (n == 20)
      endSim();
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  // step seen relative to the code before it, robust to tick phase
  task automatic step(logic [7:0] d);
    c = coarse;
    e = c + d;
    for (n = 0; n < 400 && coarse === c; n++)
      @(posedge core_clk);
    if (n == 400)
      chk("step timeout", 1, 0);
    if (n == 400)
      endSim();
    chk("coarse step", 32'(e), 32'(coarse));
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    xfer(8'h20, 32'hFF, 1'b1);
    foreach (offs[i])
    begin
      xfer(offs[i], 32'h0, 1'b0);
      chk("reset read", 32'h0, rd);
    end
    $display("test reset done");
    foreach (modes[i])
    begin
      xfer(`ADR_OFS_CTRL, 32'(modes[i]), 1'b1);
      chk("mode", 32'({modes[i][3], modes[i][0]}), 32'({dual, inv}));
    end
    sel <= 4'h0;
    xfer(`ADR_OFS_CTRL, 32'h1, 1'b1);
    sel <= 4'hF;
    chk("masked write", 32'h0, 32'(inv));
    $display("test modes done");
    xfer(`ADR_OFS_FINE, 32'hFF, 1'b1);
    xfer(`ADR_OFS_COARSE, 32'h80, 1'b1);
    xfer(`ADR_OFS_CTRL, 32'h1, 1'b1);
    chk("codes", 32'h1FF80, {15'h0, inv, fine, coarse});
    $display("test direct done");
    xfer(`ADR_OFS_CTRL, 32'h2, 1'b1);
    xfer(`ADR_OFS_COARSE, 32'h82, 1'b1);
    step(8'h01);
    step(8'h01);
    chk("slow spacing", 256, n);
    xfer(`ADR_OFS_STATUS, 32'h0, 1'b0);
    chk("status", 32'h8200, rd);
    xfer(`ADR_OFS_CTRL, 32'h6, 1'b1);
    xfer(`ADR_OFS_COARSE, 32'h7F, 1'b1);
    step(8'hFF);
    step(8'hFF);
    chk("fast spacing", 64, n);
    xfer(`ADR_OFS_COARSE, 32'h84, 1'b1);
    step(8'h01);
    xfer(`ADR_OFS_CTRL, 32'h0, 1'b1);
    chk("ramp off", 32'h84, 32'(coarse));
    $display("test ramp done");
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    per <= 1'b1;
    repeat (200) @(posedge core_clk);
    per <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("captures", 32'(rises), 32'(caps));
    xfer(`ADR_OFS_SYSREF, 32'h0, 1'b0);
    chk("seen", 32'h1, rd);
    xfer(`ADR_OFS_SYSREF, 32'h1, 1'b1);
    xfer(`ADR_OFS_SYSREF, 32'h0, 1'b0);
    chk("cleared", 32'h0, rd);
    $display("test sysref done");
    endSim();
  end
endmodule // adr_clk_ctrl_test
